// [verilog/sofc_map.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef SOFC_MAP_SVH
`define SOFC_MAP_SVH

// Register indices (byte address is four times the index)
`define SOFC_IDX_ROUTE    8'h21
`define SOFC_IDX_VLEN     8'h22
`define SOFC_IDX_HLEN     8'h23
`define SOFC_IDX_POL      8'h24
`define SOFC_IDX_CLKFMT   8'h25
`define SOFC_IDX_STATUS   8'h28

// Reset values
`define SOFC_RST_ROUTE    8'h0C
`define SOFC_RST_VLEN     8'h04
`define SOFC_RST_HLEN     8'h20
`define SOFC_RST_POL      8'hFE
`define SOFC_RST_CLKFMT   8'h72

// Routing control fields
`define SOFC_B_REGEN_SRC  7
`define SOFC_B_PLL_FILT   6
`define SOFC_B_VFILT_EN   5
`define SOFC_B_VDUR_EN    4
`define SOFC_B_AO_MODE    3
`define SOFC_B_AO_LEN     2

// Polarity and select fields
`define SOFC_B_HS_POL     7
`define SOFC_B_VS_POL     6
`define SOFC_B_DE_POL     5
`define SOFC_B_FLD_POL    4
`define SOFC_B_GS_POL     3
`define SOFC_B_CLK_INV    0

// Offset sampling timing, in pixel clocks
`define SOFC_AO_DLY_SHORT 5'd10
`define SOFC_AO_DLY_LONG  5'd16
`define SOFC_AO_SAMP_LEN  5'd6

`endif

// [verilog/sofc_pkg.sv]
// Types shared by the sync and output format block
package sofc_pkg;

	// Pixel triple, one byte per channel
	typedef struct packed {
		logic [7:0] ch_a;
		logic [7:0] ch_b;
		logic [7:0] ch_c;
	} sofc_pixel_t;

	// Sync group, active high inside the block
	typedef struct packed {
		logic hs;
		logic vs;
		logic de;
		logic field;
		logic green;
	} sofc_sync_t;

	// Offset sampling window states
	typedef enum logic [1:0] {
		SOFC_AO_IDLE = 2'b00,
		SOFC_AO_WAIT = 2'b01,
		SOFC_AO_SAMP = 2'b10
	} sofc_ao_state_t;

endpackage : sofc_pkg

// [verilog/sofc_top.sv]
// Sync conditioning and pixel output formatting with Avalon-MM registers
// How it works
// - PLL filter bit set feeds filtered hsync to PLL, raw otherwise.
// - Vsync filter starts vsync at first hsync edge, clipping one line.
// - Duration enable rebuilds filtered vsync length from programmed lines.
// - Offset sampling during clamp, or for six cycles after the post-clamp delay in mode one.
// - Post-clamp delay is 10 cycles, or 16 when length bit set.
// - Output hsync lasts the programmed pixel clocks, reset value 32.
// - Output hsync polarity bit, zero means active low.
// - Output vsync polarity bit, zero means active low.
// - Output data enable polarity bit, zero means active low.
// - Output field polarity bit, zero means active low.
// - Green sync output polarity bit, zero means active low.
// - Green sync pin shows green, raw hsync, regenerated, or PLL hsync.
// - Output clock inverted when invert bit is one, reset zero.
// - Clock select: half, pixel default, double, or 90 degree pixel.
// - Pixel repetition divides the incoming link clock for pixel rate.
// - Drive strength field, 00 weakest, 11 strongest, reset strongest.
// - Output mode maps pixel data to pins, four documented modes.
// - Enable bit makes vsync functions use regenerated hsync.
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/10ps
`include "sofc_map.svh"

module sofc_top (
	// Clock and reset
	input  wire logic                 i_clk,
	input  wire logic                 i_srst,
	// Avalon-MM slave, word addressed
	input  wire logic [7:0]           i_avs_address,
	input  wire logic                 i_avs_read,
	input  wire logic                 i_avs_write,
	input  wire logic [3:0]           i_avs_byteenable,
	input  wire logic [31:0]          i_avs_writedata,
	output logic [31:0]               o_avs_readdata,
	output logic                      o_avs_waitrequest,
	// Sync inputs, active high
	input  wire logic                 i_hsync_raw,
	input  wire logic                 i_hsync_filt,
	input  wire logic                 i_hsync_regen,
	input  wire logic                 i_vsync,
	input  wire logic                 i_green_sync,
	input  wire logic                 i_clamp,
	input  wire logic                 i_pix_rep,
	input  wire sofc_pkg::sofc_sync_t i_sync,
	input  wire sofc_pkg::sofc_pixel_t i_pixel,
	// Conditioned sync and sampling
	output logic                      o_pll_hsync,
	output logic                      o_offset_sample,
	output sofc_pkg::sofc_sync_t      o_sync,
	// Pixel outputs
	output sofc_pkg::sofc_pixel_t     o_pixel,
	// Clock and pad control
	output logic [1:0]                o_clk_sel,
	output logic                      o_clk_invert,
	output logic                      o_pix_en,
	output logic                      o_half_clk,
	output logic [1:0]                o_drive_strength,
	output logic [1:0]                o_out_mode
);

	// Register storage
	logic [7:0] route_ff;
	logic [7:0] vlen_ff;
	logic [7:0] hlen_ff;
	logic [7:0] pol_ff;
	logic [7:0] clkfmt_ff;
	logic       ack_ff;
	logic [31:0] rdata_ff;

	// Bus decode
	wire        bus_req  = i_avs_read | i_avs_write;
	wire        wr_go    = i_avs_write & ack_ff & i_avs_byteenable[0];
	wire        sel_rt   = i_avs_address == `SOFC_IDX_ROUTE;
	wire        sel_vl   = i_avs_address == `SOFC_IDX_VLEN;
	wire        sel_hl   = i_avs_address == `SOFC_IDX_HLEN;
	wire        sel_pl   = i_avs_address == `SOFC_IDX_POL;
	wire        sel_cf   = i_avs_address == `SOFC_IDX_CLKFMT;
	wire        sel_st   = i_avs_address == `SOFC_IDX_STATUS;
	wire [7:0]  wbyte    = i_avs_writedata[7:0];

	// Waitrequest drops in the cycle after the request is seen
	assign o_avs_waitrequest = bus_req & ~ack_ff;
	assign o_avs_readdata    = rdata_ff;

	// Status byte, assembled below
	logic [7:0] status_w;

	// Read mux; unmapped indices read as zero
	wire [7:0] rd_mux =
		sel_rt ? route_ff :
		sel_vl ? vlen_ff :
		sel_hl ? hlen_ff :
		sel_pl ? pol_ff :
		sel_cf ? clkfmt_ff :
		sel_st ? status_w : 8'h00;

	// Acknowledge pulse and read data capture
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ack_ff   <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= bus_req & ~ack_ff;
			if (i_avs_read & ~ack_ff) begin
				rdata_ff <= {24'h00_0000, rd_mux};
			end
		end
	end

	// Register writes, taken at the edge where waitrequest is low
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			route_ff  <= `SOFC_RST_ROUTE;
			vlen_ff   <= `SOFC_RST_VLEN;
			hlen_ff   <= `SOFC_RST_HLEN;
			pol_ff    <= `SOFC_RST_POL;
			clkfmt_ff <= `SOFC_RST_CLKFMT;
		end else if (wr_go) begin
			if (sel_rt) route_ff  <= wbyte;
			if (sel_vl) vlen_ff   <= wbyte;
			if (sel_hl) hlen_ff   <= wbyte;
			if (sel_pl) pol_ff    <= wbyte;
			if (sel_cf) clkfmt_ff <= wbyte;
		end
	end

	// Control field taps
	wire regen_src = route_ff[`SOFC_B_REGEN_SRC];
	wire pll_filt  = route_ff[`SOFC_B_PLL_FILT];
	wire vfilt_en  = route_ff[`SOFC_B_VFILT_EN];
	wire vdur_en   = route_ff[`SOFC_B_VDUR_EN];
	wire ao_mode   = route_ff[`SOFC_B_AO_MODE];
	wire ao_len    = route_ff[`SOFC_B_AO_LEN];

	// Hsync routing toward the PLL and vsync functions
	wire pll_hs_w = pll_filt ? i_hsync_filt : i_hsync_raw;
	wire line_hs  = regen_src ? i_hsync_regen : i_hsync_raw;

	// Edge history for the sync inputs
	logic line_hs_d_ff;
	logic out_hs_d_ff;
	logic clamp_d_ff;
	wire  line_hs_rise = line_hs & ~line_hs_d_ff;
	wire  out_hs_rise  = pll_hs_w & ~out_hs_d_ff;
	wire  clamp_fall   = ~i_clamp & clamp_d_ff;

	// Previous-cycle copies; reset to the idle low level of each input
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			line_hs_d_ff <= 1'b0;
			out_hs_d_ff  <= 1'b0;
			clamp_d_ff   <= 1'b0;
		end else begin
			line_hs_d_ff <= line_hs;
			out_hs_d_ff  <= pll_hs_w;
			clamp_d_ff   <= i_clamp;
		end
	end

	// Vsync filter: assert only at the first line edge inside vsync
	logic vfilt_ff;
	wire  nxt_vfilt = ~i_vsync ? 1'b0 :
		(line_hs_rise ? 1'b1 : vfilt_ff);

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			vfilt_ff <= 1'b0;
		end else begin
			vfilt_ff <= nxt_vfilt;
		end
	end

	// Vsync ahead of the duration block
	wire vs_pre = vfilt_en ? vfilt_ff : i_vsync;
	logic vs_pre_d_ff;
	wire  vs_pre_rise = vs_pre & ~vs_pre_d_ff;

	// Duration block: stretch vsync to the programmed line count
	logic       vdur_ff;
	logic [7:0] vcnt_ff;
	wire        vcnt_done = vcnt_ff == 8'h01;
	wire        vlen_zero = vlen_ff == 8'h00;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			vs_pre_d_ff <= 1'b0;
			vdur_ff     <= 1'b0;
			vcnt_ff     <= 8'h00;
		end else begin
			vs_pre_d_ff <= vs_pre;
			if (vs_pre_rise && !vlen_zero) begin
				vdur_ff <= 1'b1;
				vcnt_ff <= vlen_ff;
			end else if (vdur_ff && line_hs_rise) begin
				vcnt_ff <= vcnt_ff - 8'h01;
				if (vcnt_done) vdur_ff <= 1'b0;
			end
		end
	end

	// Rebuilt vsync replaces the filtered one when enabled
	wire vs_int = vdur_en ? vdur_ff : vs_pre;

	// Output hsync: fixed pulse width in pixel clocks
	logic       hs_out_ff;
	logic [7:0] hcnt_ff;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			hs_out_ff <= 1'b0;
			hcnt_ff   <= 8'h00;
		end else if (out_hs_rise && hlen_ff != 8'h00) begin
			hs_out_ff <= 1'b1;
			hcnt_ff   <= hlen_ff - 8'h01;
		end else if (hcnt_ff != 8'h00) begin
			hcnt_ff <= hcnt_ff - 8'h01;
		end else begin
			hs_out_ff <= 1'b0;
		end
	end

	// Offset sampling window state machine
	sofc_pkg::sofc_ao_state_t ao_st_ff;
	sofc_pkg::sofc_ao_state_t nxt_ao_st;
	logic [4:0] ao_cnt_ff;
	logic [4:0] nxt_ao_cnt;
	wire  [4:0] ao_dly = ao_len ? `SOFC_AO_DLY_LONG : `SOFC_AO_DLY_SHORT;

	always_comb begin
		nxt_ao_st  = ao_st_ff;
		nxt_ao_cnt = ao_cnt_ff;
		case (ao_st_ff)
			sofc_pkg::SOFC_AO_IDLE: begin
				if (ao_mode && clamp_fall) begin
					nxt_ao_st  = sofc_pkg::SOFC_AO_WAIT;
					nxt_ao_cnt = ao_dly - 5'd1;
				end
			end
			sofc_pkg::SOFC_AO_WAIT: begin
				if (ao_cnt_ff == 5'd0) begin
					nxt_ao_st  = sofc_pkg::SOFC_AO_SAMP;
					nxt_ao_cnt = `SOFC_AO_SAMP_LEN - 5'd1;
				end else begin
					nxt_ao_cnt = ao_cnt_ff - 5'd1;
				end
			end
			sofc_pkg::SOFC_AO_SAMP: begin
				if (ao_cnt_ff == 5'd0) begin
					nxt_ao_st = sofc_pkg::SOFC_AO_IDLE;
				end else begin
					nxt_ao_cnt = ao_cnt_ff - 5'd1;
				end
			end
			default: begin
				nxt_ao_st  = sofc_pkg::SOFC_AO_IDLE;
				nxt_ao_cnt = 5'd0;
			end
		endcase
		if (!ao_mode) begin
			nxt_ao_st  = sofc_pkg::SOFC_AO_IDLE;
			nxt_ao_cnt = 5'd0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ao_st_ff  <= sofc_pkg::SOFC_AO_IDLE;
			ao_cnt_ff <= 5'd0;
		end else begin
			ao_st_ff  <= nxt_ao_st;
			ao_cnt_ff <= nxt_ao_cnt;
		end
	end

	// Sample flag: clamp itself in mode 0, the window in mode 1
	wire ao_samp_w = ao_mode ? (ao_st_ff == sofc_pkg::SOFC_AO_SAMP)
		: i_clamp;

	// Green sync source select
	logic gs_src;
	always_comb begin
		case (pol_ff[2:1])
			2'b00:   gs_src = i_green_sync;
			2'b01:   gs_src = i_hsync_raw;
			2'b10:   gs_src = i_hsync_regen;
			2'b11:   gs_src = pll_hs_w;
			default: gs_src = i_green_sync;
		endcase
	end

	// Pixel rate divider: every other cycle under pixel repetition
	logic div_ff;
	logic half_ff;
	wire  pix_en_w = ~i_pix_rep | div_ff;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			div_ff  <= 1'b0;
			half_ff <= 1'b0;
		end else begin
			div_ff <= i_pix_rep ? ~div_ff : 1'b0;
			if (pix_en_w) half_ff <= ~half_ff;
		end
	end

	// Output mode data mapping; phase alternates per pixel
	sofc_pkg::sofc_pixel_t map_w;
	always_comb begin
		map_w = i_pixel;
		case (clkfmt_ff[3:2])
			2'b00: map_w = i_pixel;
			2'b01: begin
				map_w.ch_b = half_ff ? i_pixel.ch_c : i_pixel.ch_b;
				map_w.ch_c = half_ff ? i_pixel.ch_a : i_pixel.ch_b;
			end
			2'b10: begin
				map_w.ch_a = half_ff ? i_pixel.ch_b : i_pixel.ch_a;
				map_w.ch_b = half_ff ? i_pixel.ch_c : i_pixel.ch_b;
				map_w.ch_c = half_ff ? i_pixel.ch_a : i_pixel.ch_c;
			end
			2'b11: begin
				map_w.ch_b = {i_pixel.ch_b[3:0], i_pixel.ch_c[3:0]};
				map_w.ch_c = half_ff ? i_pixel.ch_c : i_pixel.ch_b;
			end
			default: map_w = i_pixel;
		endcase
	end

	// Polarity application on the internal active-high sync
	sofc_pkg::sofc_sync_t sync_w;
	assign sync_w.hs    = ~(hs_out_ff ^ pol_ff[`SOFC_B_HS_POL]);
	assign sync_w.vs    = ~(vs_int ^ pol_ff[`SOFC_B_VS_POL]);
	assign sync_w.de    = ~(i_sync.de ^ pol_ff[`SOFC_B_DE_POL]);
	assign sync_w.field = ~(i_sync.field ^ pol_ff[`SOFC_B_FLD_POL]);
	assign sync_w.green = ~(gs_src ^ pol_ff[`SOFC_B_GS_POL]);

	// Registered outputs; controls change only at a pixel boundary
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_pll_hsync      <= 1'b0;
			o_offset_sample  <= 1'b0;
			o_sync           <= '0;
			o_pixel          <= '0;
			o_clk_sel        <= 2'b01;
			o_clk_invert     <= 1'b0;
			o_drive_strength <= 2'b11;
			o_out_mode       <= 2'b00;
			o_half_clk       <= 1'b0;
		end else begin
			o_pll_hsync     <= pll_hs_w;
			o_offset_sample <= ao_samp_w;
			o_half_clk      <= half_ff;
			if (pix_en_w) begin
				o_sync           <= sync_w;
				o_pixel          <= map_w;
				o_clk_sel        <= clkfmt_ff[7:6];
				o_clk_invert     <= pol_ff[`SOFC_B_CLK_INV];
				o_drive_strength <= clkfmt_ff[5:4];
				o_out_mode       <= clkfmt_ff[3:2];
			end
		end
	end

	// Pixel enable goes out unregistered as the stream strobe
	assign o_pix_en = pix_en_w;

	// Status: live block state for software
	assign status_w = {2'b00, ao_st_ff, vdur_ff, vfilt_ff,
		hs_out_ff, div_ff};

endmodule : sofc_top

// [verif/sofc_assertions.sv]
// Checker for the sync and output format block
`timescale 1ns/10ps
`include "sofc_map.svh"
module sofc_assertions (
	// Clock, reset and bus
	input wire logic                 i_clk,
	input wire logic                 i_srst,
	input wire logic [7:0]           i_avs_address,
	input wire logic                 i_avs_write,
	input wire logic [3:0]           i_avs_byteenable,
	input wire logic [31:0]          i_avs_writedata,
	input wire logic                 o_avs_waitrequest,
	// Sync inputs
	input wire logic                 i_hsync_raw,
	input wire logic                 i_hsync_filt,
	input wire logic                 i_hsync_regen,
	input wire logic                 i_green_sync,
	input wire logic                 i_clamp,
	input wire logic                 i_pix_rep,
	input wire sofc_pkg::sofc_sync_t i_sync,
	// Outputs
	input wire logic                 o_pll_hsync,
	input wire logic                 o_offset_sample,
	input wire sofc_pkg::sofc_sync_t o_sync,
	input wire logic [1:0]           o_clk_sel,
	input wire logic                 o_clk_invert,
	input wire logic                 o_pix_en,
	input wire logic [1:0]           o_drive_strength,
	input wire logic [1:0]           o_out_mode
);
	logic [7:0] rt_ff, hl_ff, pl_ff, cf_ff, hc_ff;
	logic [6:0] cp_ff;
	logic [1:0] df_ff;
	logic       pd_ff, live_ff, pll_ff, gr_ff;
	// Hsync expected at the PLL, from the shadow routing bit
	wire        pll_x = rt_ff[6] ? i_hsync_filt : i_hsync_raw;
	// Accepted writes and selected green source
	wire        wr_ok = i_avs_write & ~o_avs_waitrequest
		& i_avs_byteenable[0];
	wire  [3:0] gsrc = {pll_x, i_hsync_regen, i_hsync_raw,
		i_green_sync};
	wire        hs_act = o_sync.hs == pd_ff;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	// Shadow copies of the control registers
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			rt_ff <= 8'h0C;
			hl_ff <= 8'h20;
			pl_ff <= 8'hFE;
			cf_ff <= 8'h72;
		end else if (wr_ok) begin
			case (i_avs_address)
				`SOFC_IDX_ROUTE: rt_ff <= i_avs_writedata[7:0];
				`SOFC_IDX_HLEN: hl_ff <= i_avs_writedata[7:0];
				`SOFC_IDX_POL: pl_ff <= i_avs_writedata[7:0];
				`SOFC_IDX_CLKFMT: cf_ff <= i_avs_writedata[7:0];
				default: ;
			endcase
		end
	end
	// Expected outputs one edge ahead, and pulse length counter
	always_ff @(posedge i_clk) begin
		live_ff <= !i_srst;
		pd_ff <= pl_ff[7];
		hc_ff <= hs_act ? hc_ff + 8'h01 : 8'h00;
		pll_ff <= pll_x;
		if (o_pix_en) begin
			df_ff <= {i_sync.de ~^ pl_ff[5], i_sync.field ~^ pl_ff[4]};
			gr_ff <= gsrc[pl_ff[2:1]] ~^ pl_ff[3];
			cp_ff <= {cf_ff[7:6], pl_ff[0], cf_ff[5:2]};
		end
	end
	property p_pll;
		live_ff |-> o_pll_hsync == pll_ff;
	endproperty
	a_pll: assert property (p_pll)
		else $error("pll hsync source wrong");
	property p_sync;
		live_ff |-> {o_sync.de, o_sync.field} == df_ff;
	endproperty
	a_sync: assert property (p_sync)
		else $error("enable or field polarity wrong");
	property p_grn;
		live_ff |-> o_sync.green == gr_ff;
	endproperty
	a_grn: assert property (p_grn)
		else $error("green sync output wrong");
	property p_copy;
		live_ff |-> {o_clk_sel, o_clk_invert, o_drive_strength,
			o_out_mode} == cp_ff;
	endproperty
	a_copy: assert property (p_copy)
		else $error("clock or format control wrong");
	property p_hlen;
		live_ff && $fell(hs_act) && !i_pix_rep |-> hc_ff == hl_ff;
	endproperty
	a_hlen: assert property (p_hlen)
		else $error("output hsync length wrong");
	property p_ofs_s;
		$fell(i_clamp) && rt_ff[3] && !rt_ff[2]
			|-> ##12 $rose(o_offset_sample);
	endproperty
	a_ofs_s: assert property (p_ofs_s)
		else $error("short sampling delay wrong");
	property p_ofs_l;
		$fell(i_clamp) && rt_ff[3] && rt_ff[2]
			|-> ##18 $rose(o_offset_sample);
	endproperty
	a_ofs_l: assert property (p_ofs_l)
		else $error("long sampling delay wrong");
	property p_ofs_w;
		$rose(o_offset_sample) && rt_ff[3]
			|-> o_offset_sample[*6] ##1 !o_offset_sample;
	endproperty
	a_ofs_w: assert property (p_ofs_w)
		else $error("sampling window width wrong");
	property p_rep;
		live_ff && i_pix_rep && $past(i_pix_rep)
			|-> o_pix_en != $past(o_pix_en);
	endproperty
	a_rep: assert property (p_rep)
		else $error("pixel enable not alternating");
	// Main scenarios reached
	c_hs: cover property (live_ff && $fell(hs_act));
	c_ofs: cover property ($rose(o_offset_sample));
	c_rep: cover property (i_pix_rep && o_pix_en);
endmodule : sofc_assertions

bind sofc_top sofc_assertions u_chk (.*);

// [verif/sofc_sink.sv]
// Receiver model that latches each accepted pixel
`timescale 1ns/10ps
module sofc_sink (
	// Clock and stream from the block
	input  wire logic                  i_clk,
	input  wire logic                  i_srst,
	input  wire logic                  i_pix_en,
	input  wire sofc_pkg::sofc_pixel_t i_pixel,
	// Last accepted pixel and count
	output sofc_pkg::sofc_pixel_t      o_pixel,
	output logic [15:0]                o_count
);
	// Take one pixel on every enabled clock
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_count <= 16'h0000;
		end else if (i_pix_en) begin
			o_pixel <= i_pixel;
			o_count <= o_count + 16'h0001;
		end
	end
endmodule : sofc_sink

// [verif/testbench.sv]
// Self-checking bench for the sync and output format block
`timescale 1ns/10ps
module testbench;
	logic        i_clk, i_srst, i_avs_read, i_avs_write;
	logic [7:0]  i_avs_address;
	logic [3:0]  i_avs_byteenable;
	logic [31:0] i_avs_writedata, o_avs_readdata;
	logic        o_avs_waitrequest, i_hsync_raw, i_hsync_filt;
	logic        i_hsync_regen, i_vsync, i_green_sync, i_clamp;
	logic        i_pix_rep, o_pll_hsync, o_offset_sample, o_clk_invert;
	logic        o_pix_en, o_half_clk;
	logic [1:0]  o_clk_sel, o_drive_strength, o_out_mode;
	logic [15:0] rx_cnt;
	sofc_pkg::sofc_sync_t  i_sync, o_sync;
	sofc_pkg::sofc_pixel_t i_pixel, o_pixel, rx_px;
	int          miscompares, checked;
	logic [7:0]  q;

	sofc_top DUT (.*);
	sofc_sink u_sink (.i_clk(i_clk), .i_srst(i_srst),
		.i_pix_en(o_pix_en), .i_pixel(o_pixel), .o_pixel(rx_px),
		.o_count(rx_cnt));

	// Pixel clock
	initial begin
		i_clk = 0;
		forever #20 i_clk = ~i_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// One bus transfer, held until waitrequest is sampled low at a rise
	task automatic bus(input logic w, input logic [7:0] a, d);
		@(posedge i_clk);
		i_avs_write <= w;
		i_avs_read <= !w;
		i_avs_address <= a;
		i_avs_writedata <= {24'h00_0000, d};
		@(posedge i_clk);
		while (o_avs_waitrequest) @(posedge i_clk);
		q = o_avs_readdata[7:0];
		i_avs_write <= 0;
		i_avs_read <= 0;
	endtask : bus

	task automatic t_regs;
		logic [7:0] a [6] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h30};
		logic [7:0] e [6] = '{8'h0C, 8'h04, 8'h20, 8'hFE, 8'h72, 8'h00};
		for (int i = 0; i < 6; i++) begin
			bus(0, a[i], 0);
			chk(q, e[i]);
		end
		bus(1, 8'h30, 8'h55);
		bus(0, 8'h30, 0);
		chk(q, 0);
		i_avs_byteenable <= 4'h0;
		bus(1, 8'h23, 8'h11);
		i_avs_byteenable <= 4'h1;
		bus(0, 8'h23, 0);
		chk(q, 8'h20);
	endtask : t_regs

	task automatic t_pol;
		i_sync <= 5'b00100;
		for (int p = 0; p < 2; p++) begin
			bus(1, 8'h24, p ? 8'hF0 : 8'h00);
			repeat (3) @(posedge i_clk);
			chk(o_sync[4:1], p ? 4'b0010 : 4'b1101);
		end
	endtask : t_pol

	task automatic t_green;
		bus(1, 8'h21, 8'h4C);
		for (int i = 0; i < 8; i++) begin
			{i_hsync_filt, i_hsync_regen, i_hsync_raw, i_green_sync}
				<= 4'h1 << i[2:1];
			bus(1, 8'h24, {4'hF, i[0], i[2:1], 1'b0});
			repeat (3) @(posedge i_clk);
			chk(o_sync.green, i[0]);
		end
	endtask : t_green

	task automatic t_hs;
		int l [3] = '{0, 1, 5};
		int n;
		{i_hsync_filt, i_hsync_regen, i_hsync_raw} <= 3'b000;
		// Let an earlier output hsync pulse run out first
		repeat (32) @(posedge i_clk);
		bus(1, 8'h24, 8'hF0);
		foreach (l[i]) begin
			bus(1, 8'h23, l[i][7:0]);
			repeat (10) @(posedge i_clk);
			i_hsync_filt <= 1;
			repeat (2) @(posedge i_clk);
			i_hsync_filt <= 0;
			n = 0;
			repeat (14) @(negedge i_clk) n += o_sync.hs;
			chk(n, l[i]);
		end
	endtask : t_hs

	// Vsync filter, line source and duration rebuild
	task automatic t_vs;
		bus(1, 8'h22, 8'h00);
		bus(1, 8'h21, 8'hA0);
		i_vsync <= 1;
		repeat (3) @(posedge i_clk);
		chk(o_sync.vs, 0);
		i_hsync_raw <= 1;
		@(posedge i_clk);
		i_hsync_raw <= 0;
		repeat (4) @(posedge i_clk);
		chk(o_sync.vs, 0);
		i_hsync_regen <= 1;
		@(posedge i_clk);
		i_hsync_regen <= 0;
		repeat (4) @(posedge i_clk);
		chk(o_sync.vs, 1);
		i_vsync <= 0;
		repeat (3) @(posedge i_clk);
		chk(o_sync.vs, 0);
		bus(1, 8'h22, 8'h02);
		bus(1, 8'h21, 8'hB0);
		i_vsync <= 1;
		for (int i = 0; i < 3; i++) begin
			i_hsync_regen <= 1;
			@(posedge i_clk);
			i_hsync_regen <= 0;
			i_vsync <= 0;
			repeat (4) @(posedge i_clk);
			chk(o_sync.vs, i < 2);
		end
	endtask : t_vs

	task automatic t_ofs;
		int d [2];
		int w;
		for (int i = 0; i < 2; i++) begin
			bus(1, 8'h21, i ? 8'h4C : 8'h48);
			i_clamp <= 1;
			repeat (3) @(posedge i_clk);
			i_clamp <= 0;
			d[i] = 0;
			w = 0;
			@(negedge i_clk);
			while (!o_offset_sample && d[i] < 40) @(negedge i_clk) d[i]++;
			while (o_offset_sample && w < 20) @(negedge i_clk) w++;
			chk(w, 6);
		end
		chk(d[1] - d[0], 6);
		bus(1, 8'h21, 8'h40);
		i_clamp <= 1;
		repeat (3) @(posedge i_clk);
		chk(o_offset_sample, 1);
		i_clamp <= 0;
		repeat (2) @(posedge i_clk);
		chk(o_offset_sample, 0);
	endtask : t_ofs

	task automatic t_fmt;
		for (int i = 0; i < 4; i++) begin
			bus(1, 8'h25, {i[1:0], ~i[1:0], i[1:0], 2'b10});
			repeat (3) @(posedge i_clk);
			chk({o_clk_sel, o_drive_strength, o_out_mode},
				{i[1:0], ~i[1:0], i[1:0]});
		end
		bus(1, 8'h24, 8'hF1);
		bus(1, 8'h25, 8'h70);
		i_pixel <= 24'h12_3456;
		repeat (4) @(posedge i_clk);
		chk(o_clk_invert, 1);
		chk(rx_px, 24'h12_3456);
		q[0] = o_half_clk;
		@(posedge i_clk);
		chk(o_half_clk, !q[0]);
	endtask : t_fmt

	task automatic t_rep;
		logic [15:0] c0;
		i_pix_rep <= 1;
		repeat (3) @(posedge i_clk);
		c0 = rx_cnt;
		repeat (10) @(posedge i_clk);
		chk(rx_cnt - c0, 5);
		i_pix_rep <= 0;
	endtask : t_rep

	task automatic conclude;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude

	// Cut a hang short
	initial begin
		repeat (20000) @(posedge i_clk);
		miscompares++;
		conclude();
	end

	// Reset, then the scenarios
	initial begin
		{i_srst, i_avs_byteenable} = 5'h11;
		{i_avs_read, i_avs_write, i_avs_address, i_avs_writedata} = 0;
		{i_hsync_raw, i_hsync_filt, i_hsync_regen, i_vsync} = 0;
		{i_green_sync, i_clamp, i_pix_rep, i_sync, i_pixel} = 0;
		repeat (16) @(posedge i_clk);
		i_srst <= 0;
		t_regs();
		t_pol();
		t_green();
		t_hs();
		t_vs();
		t_ofs();
		t_fmt();
		t_rep();
		conclude();
	end
endmodule : testbench
